/* File: hdl/map_cmd.v */
`timescale 1ns/1ps
`include "map_cmd_defs.vh"
module map_cmd (
    // Clock and reset
    input wire sys_clk,
    input wire nrst,
    // Serial link
    input wire sck,
    input wire cs_n,
    input wire mosi,
    output reg miso_ff,
    output reg miso_oe_ff,
    // Memory and register space, asynchronous read
    output reg [15:0] mem_addr_ff,
    output reg mem_rd_ff,
    output reg mem_we_ff,
    output reg [15:0] mem_wdata_ff,
    input wire [15:0] mem_rdata,
    // Address sources
    input wire [15:0] first_remote_terminal_cw_addr,
    input wire [15:0] second_remote_terminal_cw_addr,
    input wire [15:0] int_log_last_addr,
    // Pointer register write from register block
    input wire ptr_wr_en,
    input wire [1:0] ptr_wr_idx,
    input wire [15:0] ptr_wr_data,
    // Pointer status
    output reg [1:0] ptr_sel_ff,
    output wire [15:0] address_pointer_zero,
    output wire [15:0] address_pointer_one,
    output wire [15:0] address_pointer_two,
    output wire [15:0] address_pointer_three
);
    localparam S_IDLE = 3'h0;
    localparam S_OPC = 3'h1;
    localparam S_CAP = 3'h2;
    localparam S_DATA = 3'h3;
    localparam S_SKIP = 3'h4;

    reg sck_s1_ff, sck_s2_ff, sck_d_ff;
    reg cs_s1_ff, cs_s2_ff;
    reg mosi_s1_ff, mosi_s2_ff;
    reg [2:0] state_ff;
    reg [2:0] bcnt_ff;
    reg [6:0] op_ff;
    reg [3:0] dbit_ff;
    reg [15:0] sh_ff;
    reg [15:0] pf_ff;
    reg [15:0] addr_ff;
    reg [15:0] ptr_ff [0:3];
    reg ind_ff;
    reg wr_ff;
    reg first_ff;
    reg [1:0] post_ff;

    wire cs_act = ~cs_s2_ff;
    wire rise = sck_s2_ff & ~sck_d_ff;
    wire fall = ~sck_s2_ff & sck_d_ff;
    wire [7:0] op_in = {op_ff, mosi_s2_ff};
    wire [15:0] cur = ptr_ff[ptr_sel_ff];
    wire [15:0] ind_addr = cur + {14'h0000, op_in[4:3]} - 16'h0001;
    wire [15:0] addr_inc = addr_ff + 16'h0001;
    wire [15:0] wr_addr = first_ff ? addr_ff : addr_inc;

    assign address_pointer_zero = ptr_ff[0];
    assign address_pointer_one = ptr_ff[1];
    assign address_pointer_two = ptr_ff[2];
    assign address_pointer_three = ptr_ff[3];

    task go_read;
        input [15:0] a;
        begin
            addr_ff <= a;
            mem_addr_ff <= a;
            mem_rd_ff <= 1'b1;
            first_ff <= 1'b1;
            ind_ff <= 1'b0;
            wr_ff <= 1'b0;
            post_ff <= `POST_NONE;
            state_ff <= S_CAP;
        end
    endtask

    always @(posedge sys_clk) begin
        if (!nrst) begin
            sck_s1_ff <= 1'b0;
            sck_s2_ff <= 1'b0;
            sck_d_ff <= 1'b0;
            cs_s1_ff <= 1'b1;
            cs_s2_ff <= 1'b1;
            mosi_s1_ff <= 1'b0;
            mosi_s2_ff <= 1'b0;
            miso_ff <= 1'b0;
            miso_oe_ff <= 1'b0;
            mem_addr_ff <= 16'h0000;
            mem_rd_ff <= 1'b0;
            mem_we_ff <= 1'b0;
            mem_wdata_ff <= 16'h0000;
            ptr_sel_ff <= 2'h0;
            ptr_ff[0] <= `PTR_RESET;
            ptr_ff[1] <= `PTR_RESET;
            ptr_ff[2] <= `PTR_RESET;
            ptr_ff[3] <= `PTR_RESET;
            state_ff <= S_IDLE;
            bcnt_ff <= 3'h0;
            op_ff <= 7'h00;
            dbit_ff <= 4'h0;
            sh_ff <= 16'h0000;
            pf_ff <= 16'h0000;
            addr_ff <= 16'h0000;
            ind_ff <= 1'b0;
            wr_ff <= 1'b0;
            first_ff <= 1'b0;
            post_ff <= `POST_NONE;
        end else begin
            sck_s1_ff <= sck;
            sck_s2_ff <= sck_s1_ff;
            sck_d_ff <= sck_s2_ff;
            cs_s1_ff <= cs_n;
            cs_s2_ff <= cs_s1_ff;
            mosi_s1_ff <= mosi;
            mosi_s2_ff <= mosi_s1_ff;
            mem_rd_ff <= 1'b0;
            mem_we_ff <= 1'b0;
            miso_ff <= cs_act & ~wr_ff & sh_ff[15];
            miso_oe_ff <= cs_act;
            if (!cs_act) begin
                state_ff <= S_IDLE;
                bcnt_ff <= 3'h0;
                dbit_ff <= 4'h0;
                wr_ff <= 1'b0;
                sh_ff <= 16'h0000;
            end else begin
                case (state_ff)
                    S_IDLE: begin
                        state_ff <= S_OPC;
                    end
                    S_OPC: begin
                        if (rise) begin
                            op_ff <= op_in[6:0];
                            bcnt_ff <= bcnt_ff + 3'h1;
                            if (bcnt_ff == 3'h7) begin
                                state_ff <= S_SKIP;
                                if (op_in[7:2] == `OP_SEL_HI) begin
                                    ptr_sel_ff <= op_in[1:0]; // [RULE_01]
                                end
                                case (op_in)
                                    `OP_ADD1: ptr_ff[ptr_sel_ff] <= cur + 16'h0001; // [RULE_02]
                                    `OP_ADD2: ptr_ff[ptr_sel_ff] <= cur + 16'h0002; // [RULE_02]
                                    `OP_ADD4: ptr_ff[ptr_sel_ff] <= cur + 16'h0004; // [RULE_02]
                                    `OP_RD: begin
                                        go_read(cur); // [RULE_03]
                                    end
                                    `OP_WR, `OP_INC_WR: begin
                                        addr_ff <= op_in[3] ? cur + 16'h0001 : cur; // [RULE_04] [RULE_05]
                                        ptr_ff[ptr_sel_ff] <= op_in[3] ? cur + 16'h0001 : cur; // [RULE_05]
                                        wr_ff <= 1'b1;
                                        first_ff <= 1'b1;
                                        ind_ff <= 1'b0;
                                        post_ff <= `POST_NONE;
                                        dbit_ff <= 4'h0;
                                        state_ff <= S_DATA;
                                    end
                                    `OP_FIRST_TERM_RD: begin
                                        ptr_ff[ptr_sel_ff] <= first_remote_terminal_cw_addr; // [RULE_06]
                                        go_read(first_remote_terminal_cw_addr);
                                    end
                                    `OP_SECOND_TERM_RD: begin
                                        ptr_ff[ptr_sel_ff] <= second_remote_terminal_cw_addr; // [RULE_07]
                                        go_read(second_remote_terminal_cw_addr);
                                    end
                                    `OP_IND0_RD, `OP_IND1_RD, `OP_IND2_RD,
                                    `OP_IND0_WR, `OP_IND1_WR, `OP_IND2_WR: begin
                                        ptr_ff[ptr_sel_ff] <= ind_addr; // [RULE_08] [RULE_09] [RULE_11] [RULE_12]
                                        go_read(ind_addr);
                                        ind_ff <= 1'b1;
                                        wr_ff <= op_in[7];
                                    end
                                    `OP_RD_ADD4: begin
                                        go_read(cur);
                                        post_ff <= `POST_ADD4;
                                    end
                                    `OP_LOG_RD: begin
                                        ptr_ff[ptr_sel_ff] <= int_log_last_addr; // [RULE_15]
                                        go_read(int_log_last_addr);
                                        post_ff <= `POST_DEC;
                                    end
                                    default: begin
                                    end
                                endcase
                            end
                        end
                    end
                    S_CAP: begin
                        if (ind_ff) begin
                            // Indirect hop: pointer takes the addressed word
                            ptr_ff[ptr_sel_ff] <= mem_rdata; // [RULE_10] [RULE_13]
                            addr_ff <= mem_rdata;
                            ind_ff <= 1'b0;
                            if (wr_ff) begin
                                dbit_ff <= 4'h0;
                                state_ff <= S_DATA;
                            end else begin
                                mem_addr_ff <= mem_rdata;
                                mem_rd_ff <= 1'b1;
                            end
                        end else if (first_ff) begin
                            sh_ff <= mem_rdata;
                            first_ff <= 1'b0;
                            dbit_ff <= 4'h0;
                            if (post_ff == `POST_ADD4) begin
                                ptr_ff[ptr_sel_ff] <= addr_ff + 16'h0004; // [RULE_14]
                            end
                            if (post_ff == `POST_DEC) begin
                                ptr_ff[ptr_sel_ff] <= addr_ff - 16'h0001; // [RULE_15]
                            end
                            mem_addr_ff <= addr_inc;
                            mem_rd_ff <= 1'b1;
                        end else begin
                            pf_ff <= mem_rdata;
                            state_ff <= S_DATA;
                        end
                    end
                    S_DATA: begin
                        if (wr_ff) begin
                            if (rise) begin
                                sh_ff <= {sh_ff[14:0], mosi_s2_ff};
                                dbit_ff <= dbit_ff + 4'h1;
                                if (dbit_ff == 4'hf) begin
                                    mem_we_ff <= 1'b1; // [RULE_04] [RULE_11] [RULE_13]
                                    mem_addr_ff <= wr_addr;
                                    mem_wdata_ff <= {sh_ff[14:0], mosi_s2_ff};
                                    addr_ff <= wr_addr;
                                    ptr_ff[ptr_sel_ff] <= wr_addr;
                                    first_ff <= 1'b0;
                                end
                            end
                        end else begin
                            if (rise) begin
                                dbit_ff <= dbit_ff + 4'h1;
                                if (dbit_ff == 4'hf) begin
                                    // Word boundary: next sequential word
                                    sh_ff <= pf_ff; // [RULE_17]
                                    addr_ff <= addr_inc;
                                    if (post_ff == `POST_NONE) begin
                                        ptr_ff[ptr_sel_ff] <= addr_inc; // [RULE_17]
                                    end
                                    mem_addr_ff <= addr_inc + 16'h0001;
                                    mem_rd_ff <= 1'b1;
                                    state_ff <= S_CAP;
                                end
                            end else if (fall && dbit_ff != 4'h0) begin
                                sh_ff <= {sh_ff[14:0], 1'b0};
                                // Next bit out at once, settled before the host's rising edge
                                miso_ff <= sh_ff[14]; // [RULE_03]
                            end
                        end
                    end
                    S_SKIP: begin
                    end
                    default: begin
                        state_ff <= S_IDLE;
                    end
                endcase
            end
            if (ptr_wr_en) begin
                ptr_ff[ptr_wr_idx] <= ptr_wr_data; // [RULE_18]
            end
        end
    end
endmodule

/* File: hdl/map_cmd_defs.vh */
// Operation
// (RULE_01) D8..DB select the enabled pointer
// (RULE_02) D0/D2/D4 add 1/2/4, no data
// (RULE_03) 40 reads word at pointer
// (RULE_04) C0 writes word at pointer
// (RULE_05) C8 increments pointer then writes
// (RULE_06) 48 loads pointer from terminal one, reads
// (RULE_07) 50 loads pointer from terminal two, reads
// (RULE_08) 78 adds 2, loads indirect, reads
// (RULE_09) 68/70 first add 0/1
// (RULE_10) 68/70 then indirect load and read
// (RULE_11) F8 adds 2, loads indirect, writes
// (RULE_12) E8/F0 first add 0/1
// (RULE_13) E8/F0 then indirect load and write
// (RULE_14) 60 reads then adds 4
// (RULE_15) 58 loads log address, reads, decrements
// (RULE_16) Host sends arithmetic ops alone, then deselects
// (RULE_17) Continued clocking reads next sequential word
// (RULE_18) Host loads pointer via register write
`ifndef MAP_CMD_DEFS_VH
`define MAP_CMD_DEFS_VH
`define REG_PTR0 16'h000b
`define REG_PTR1 16'h000c
`define REG_PTR2 16'h000d
`define REG_PTR3 16'h000e
`define REG_FIRST_TERM_CW 16'h0003
`define REG_SECOND_TERM_CW 16'h0005
`define PTR_RESET 16'h0000
`define OP_SEL_HI 6'h36
`define OP_ADD1 8'hd0
`define OP_ADD2 8'hd2
`define OP_ADD4 8'hd4
`define OP_RD 8'h40
`define OP_WR 8'hc0
`define OP_INC_WR 8'hc8
`define OP_FIRST_TERM_RD 8'h48
`define OP_SECOND_TERM_RD 8'h50
`define OP_IND0_RD 8'h68
`define OP_IND1_RD 8'h70
`define OP_IND2_RD 8'h78
`define OP_IND0_WR 8'he8
`define OP_IND1_WR 8'hf0
`define OP_IND2_WR 8'hf8
`define OP_RD_ADD4 8'h60
`define OP_LOG_RD 8'h58
`define POST_NONE 2'h0
`define POST_ADD4 2'h1
`define POST_DEC 2'h2
`define SCK_PERIOD_NS 200
`endif

/* File: test/map_cmd_monitor.sv */
`timescale 1ns/1ps
module map_cmd_monitor (
    // Clock and reset
    input wire sys_clk,
    input wire nrst,
    // Observed ports
    input wire miso_ff,
    input wire miso_oe_ff,
    input wire mem_rd_ff,
    input wire mem_we_ff,
    input wire ptr_wr_en,
    input wire [1:0] ptr_wr_idx,
    input wire [15:0] ptr_wr_data,
    input wire [1:0] ptr_sel_ff,
    input wire [15:0] address_pointer_zero,
    input wire [15:0] address_pointer_one,
    input wire [15:0] address_pointer_two,
    input wire [15:0] address_pointer_three
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    wire [63:0] ptrs = {address_pointer_three, address_pointer_two, address_pointer_one, address_pointer_zero};
    property p_rst;
        disable iff (1'b0) $rose(nrst) |-> ptrs == 64'h0 && ptr_sel_ff == 2'h0 && !miso_oe_ff;
    endproperty
    a_rst: assert property (p_rst) else $error("state not cleared by reset");
    property p_ptr_wr;
        ptr_wr_en |=> ptrs[{$past(ptr_wr_idx), 4'h0} +: 16] == $past(ptr_wr_data);
    endproperty
    a_ptr_wr: assert property (p_ptr_wr) else $error("pointer write lost");
    property p_hold;
        !miso_oe_ff && !ptr_wr_en |=> $stable(ptrs);
    endproperty
    a_hold: assert property (p_hold) else $error("pointer moved while idle");
    property p_sel_quiet;
        $changed(ptr_sel_ff) |-> miso_oe_ff && !mem_rd_ff && !mem_we_ff;
    endproperty
    a_sel_quiet: assert property (p_sel_quiet) else $error("select moved data");
    property p_sel_hold;
        !miso_oe_ff ##1 !miso_oe_ff |-> $stable(ptr_sel_ff);
    endproperty
    a_sel_hold: assert property (p_sel_hold) else $error("select changed while idle");
    property p_we_pulse;
        mem_we_ff |=> !mem_we_ff;
    endproperty
    a_we_pulse: assert property (p_we_pulse) else $error("write strobe too long");
    property p_we_sel;
        mem_we_ff |-> miso_oe_ff && !mem_rd_ff;
    endproperty
    a_we_sel: assert property (p_we_sel) else $error("write outside transfer");
    property p_miso_idle;
        !miso_oe_ff |-> !miso_ff;
    endproperty
    a_miso_idle: assert property (p_miso_idle) else $error("data out while idle");
    property p_rd_sel;
        mem_rd_ff |-> miso_oe_ff;
    endproperty
    a_rd_sel: assert property (p_rd_sel) else $error("read outside transfer");
    cover property (mem_we_ff);
    cover property (mem_rd_ff ##1 mem_rd_ff);
    cover property ($changed(ptr_sel_ff));
endmodule

/* File: test/spi_host_model.sv */
`timescale 1ns/1ps
module spi_host_model (
    // Clock
    input wire sys_clk,
    // Serial link
    output logic sck,
    output logic cs_n,
    output logic mosi,
    input wire miso
);
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
    end
    // Mode 0, MSB first, eight system clocks per bit
    task automatic shift(input [15:0] v, input int n, output [15:0] r);
        r = 16'h0;
        for (int i = n - 1; i >= 0; i--) begin
            mosi <= v[i];
            repeat (4) @(posedge sys_clk);
            sck <= 1'b1;
            r = {r[14:0], miso};
            repeat (4) @(posedge sys_clk);
            sck <= 1'b0;
        end
    endtask
    task automatic xfer(input [7:0] op, input int nw, input [15:0] wd, output [31:0] rd);
        logic [15:0] r;
        rd = 32'h0;
        @(posedge sys_clk);
        cs_n <= 1'b0;
        shift({8'h0, op}, 8, r);
        for (int w = 0; w < nw; w++) begin
            shift(wd, 16, r);
            rd = {rd[15:0], r};
        end
        repeat (4) @(posedge sys_clk);
        cs_n <= 1'b1;
        mosi <= ~mosi;
        repeat (8) @(posedge sys_clk);
    endtask
endmodule

/* File: test/spi_address_pointer_commands_tb.sv */
`timescale 1ns/1ps
module spi_address_pointer_commands_tb;
    logic sys_clk, nrst, ptr_wr_en;
    logic [1:0] ptr_wr_idx;
    logic [15:0] ptr_wr_data, cw1, cw2, log_a, e;
    logic [15:0] mem [0:255];
    logic [31:0] rd;
    wire sck, cs_n, mosi, miso_ff, miso_oe_ff, mem_rd_ff, mem_we_ff;
    wire [1:0] ptr_sel_ff;
    wire [15:0] mem_addr_ff, mem_wdata_ff;
    wire [15:0] ap [0:3];
    int n_errors = 0;
    int checks = 0;
    map_cmd DUT (.sys_clk(sys_clk), .nrst(nrst), .sck(sck), .cs_n(cs_n), .mosi(mosi), .miso_ff(miso_ff),
        .miso_oe_ff(miso_oe_ff), .mem_addr_ff(mem_addr_ff), .mem_rd_ff(mem_rd_ff), .mem_we_ff(mem_we_ff),
        .mem_wdata_ff(mem_wdata_ff), .mem_rdata(mem[mem_addr_ff[7:0]]),
        .first_remote_terminal_cw_addr(cw1), .second_remote_terminal_cw_addr(cw2),
        .int_log_last_addr(log_a), .ptr_wr_en(ptr_wr_en), .ptr_wr_idx(ptr_wr_idx), .ptr_wr_data(ptr_wr_data),
        .ptr_sel_ff(ptr_sel_ff), .address_pointer_zero(ap[0]), .address_pointer_one(ap[1]),
        .address_pointer_two(ap[2]), .address_pointer_three(ap[3]));
    spi_host_model host (.sys_clk(sys_clk), .sck(sck), .cs_n(cs_n), .mosi(mosi), .miso(miso_ff));
    always @(posedge sys_clk) if (mem_we_ff) mem[mem_addr_ff[7:0]] <= mem_wdata_ff;
    function automatic [15:0] v(input [15:0] a);
        v = {a[7:0] ^ 8'hc3, a[7:0] ^ 8'h5a};
    endfunction
    task chk(input [15:0] got, input [15:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task ld(input [1:0] i, input [15:0] val);
        host.xfer({6'h36, i}, 0, 16'h0, rd);
        @(posedge sys_clk);
        ptr_wr_en <= 1'b1;
        ptr_wr_idx <= i;
        ptr_wr_data <= val;
        @(posedge sys_clk);
        ptr_wr_en <= 1'b0;
        @(posedge sys_clk);
    endtask
    task stop_test;
        $display("Checks %0d, mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (40000) @(posedge sys_clk);
        n_errors++;
        $display("Error at %0t: timeout", $time);
        stop_test();
    end
    initial begin
        for (int i = 0; i < 256; i++) mem[i] = v(16'(i));
        {nrst, ptr_wr_en, ptr_wr_idx, ptr_wr_data} = '0;
        cw1 = 16'h0021;
        cw2 = 16'h0042;
        log_a = 16'h0063;
        repeat (12) @(posedge sys_clk);
        nrst <= 1'b1;
        repeat (4) @(posedge sys_clk);
        for (int i = 0; i < 4; i++) chk(ap[i], 16'h0);
        $display("Test reset done");
        for (int i = 0; i < 4; i++) begin
            ld(2'(i), 16'h0100 | 16'(i));
            chk({14'h0, ptr_sel_ff}, 16'(i));
            chk(ap[i], 16'h0100 | 16'(i));
        end
        e = 16'h0103;
        for (int j = 0; j < 3; j++) begin
            host.xfer(8'(8'hd0 + 2 * j), 0, 16'h0, rd);
            e = e + (16'h1 << j);
            chk(ap[3], e);
        end
        $display("Test select and add done");
        ld(0, 16'h0020);
        host.xfer(8'h40, 2, 16'h0, rd);
        chk(rd[31:16], v(16'h0020));
        chk(rd[15:0], v(16'h0021));
        ld(0, 16'h0080);
        host.xfer(8'hc0, 1, 16'hbeef, rd);
        chk(mem[8'h80], 16'hbeef);
        ld(0, 16'h0090);
        host.xfer(8'hc8, 1, 16'h1234, rd);
        chk(mem[8'h91], 16'h1234);
        chk(mem[8'h90], v(16'h0090));
        $display("Test direct access done");
        for (int k = 0; k < 3; k++) begin
            ld(0, 16'h0030);
            host.xfer(8'(8'h68 + 8 * k), 1, 16'h0, rd);
            chk(rd[15:0], v(v(16'h0030 + 16'(k))));
            ld(0, 16'h0040);
            host.xfer(8'(8'he8 + 8 * k), 1, 16'hc0de + 16'(k), rd);
            chk(mem[8'(8'h40 + k) ^ 8'h5a], 16'hc0de + 16'(k));
        end
        $display("Test indirect done");
        host.xfer(8'h48, 1, 16'h0, rd);
        chk(rd[15:0], v(cw1));
        host.xfer(8'h50, 1, 16'h0, rd);
        chk(rd[15:0], v(cw2));
        ld(0, 16'h0055);
        host.xfer(8'h60, 1, 16'h0, rd);
        chk(rd[15:0], v(16'h0055));
        chk(ap[0], 16'h0059);
        host.xfer(8'h58, 1, 16'h0, rd);
        chk(rd[15:0], v(log_a));
        chk(ap[0], log_a - 16'h1);
        $display("Test special done");
        stop_test();
    end
endmodule
bind map_cmd map_cmd_monitor u_mon (.sys_clk(sys_clk), .nrst(nrst), .miso_ff(miso_ff), .miso_oe_ff(miso_oe_ff),
    .mem_rd_ff(mem_rd_ff), .mem_we_ff(mem_we_ff), .ptr_wr_en(ptr_wr_en), .ptr_wr_idx(ptr_wr_idx),
    .ptr_wr_data(ptr_wr_data), .ptr_sel_ff(ptr_sel_ff), .address_pointer_zero(address_pointer_zero),
    .address_pointer_one(address_pointer_one), .address_pointer_two(address_pointer_two),
    .address_pointer_three(address_pointer_three));
